// ==== hw/acc_pkg.sv ====
/*
  Shared constants, types and helpers for the converter control block.
  Assumes an 8-bit register port and an 8-bit address space.
*/
package acc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_RESULT_LOW = 8'h78;     // Result, low byte
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'h79;    // Result, high byte
  localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h7A; // Control and status
  localparam logic [7:0] ADDR_TRIGGER_SELECT = 8'h7B; // Trigger source choice
  localparam logic [7:0] ADDR_CHANNEL_REF = 8'h7C;    // Channel, reference, alignment

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_STATUS_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_REF_RESET = 8'h00;
  localparam logic [2:0] TRIGGER_SELECT_RESET = 3'h0;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CSR_ENABLE_BIT = 7;   // converter_enable
  localparam int CSR_START_BIT = 6;    // start_conversion
  localparam int CSR_AUTO_BIT = 5;     // auto_trigger_enable
  localparam int CSR_FLAG_BIT = 4;     // conversion_done_flag
  localparam int CSR_IRQ_EN_BIT = 3;   // conversion_done_irq_enable
  localparam int CSR_PRESCALE_LSB = 0; // clock_prescale_select, 3 bits
  localparam int CHR_REF_LSB = 6;      // reference_select, 2 bits
  localparam int CHR_ALIGN_BIT = 5;    // left_align_result
  localparam int CHR_CHANNEL_LSB = 0;  // channel_gain_select, 5 bits

  // ----------------------------------------------------------------
  // Conversion lengths in converter clock ticks
  // ----------------------------------------------------------------
  localparam logic [4:0] FIRST_CONV_TICKS = 5'd25;
  localparam logic [4:0] NORMAL_CONV_TICKS = 5'd13;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  localparam logic [2:0] TRIG_FREE_RUN = 3'h0;
  localparam logic [4:0] CH_BANDGAP = 5'h1E;
  localparam logic [4:0] CH_GROUND = 5'h1F;

  typedef enum logic [1:0] {
    REF_EXTERNAL_PIN = 2'b00,
    REF_ANALOG_SUPPLY = 2'b01,
    REF_INTERNAL_1V1 = 2'b10,
    REF_INTERNAL_2V56 = 2'b11
  } acc_ref_e;

  typedef enum logic [1:0] {
    GAIN_1X = 2'b00,
    GAIN_10X = 2'b01,
    GAIN_200X = 2'b10,
    GAIN_NONE = 2'b11
  } acc_gain_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONVERT = 1'b1
  } acc_state_e;

  // Control bundle toward the analog side
  typedef struct packed {
    logic powered;        // Converter powered
    logic converting;     // Conversion running
    logic conv_start;     // One-cycle start of sampling
    logic conv_clk_tick;  // Converter clock tick
    acc_ref_e ref_select; // Applied reference
    logic single_ended;   // Single-ended input in use
    logic bandgap;        // Bandgap voltage selected
    logic ground;         // Ground selected
    logic [2:0] pos_input; // Positive or single-ended input index
    logic [1:0] neg_input; // Negative input index
    acc_gain_e gain;      // Gain of differential stage
  } acc_analog_s;

  // Prescaler division factor
  function automatic logic [7:0] acc_div_factor(input logic [2:0] sel);
    acc_div_factor = (sel <= 3'h1) ? 8'h02 : (8'h01 << sel);
  endfunction

endpackage

// ==== hw/acc_prescaler.sv ====
/*
  Divider that forms converter clock ticks from the system clock.
  Assumes a synchronous select and an enable that starts it from zero.
*/
`timescale 1ns/1ps
module acc_prescaler
  import acc_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic run,
  input wire logic [2:0] sel,
  output logic tick
);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  if (CNT_W < 8) begin : g_bad_width
    $error("acc_prescaler needs CNT_W of at least 8");
  end

  logic [CNT_W-1:0] count;      // Cycles since last tick
  logic [CNT_W-1:0] next_count;
  logic [CNT_W-1:0] limit;      // Factor minus one

  // Terminal count from select; a change takes hold at once, even mid-count
  always_comb begin
    limit = CNT_W'(acc_div_factor(sel)) - CNT_W'(1);
    tick = run && (count >= limit);
    next_count = count;
    if (!run) begin
      // Stopped while off, so each enable starts a fresh phase
      next_count = '0;
    end else if (tick) begin
      next_count = '0;
    end else begin
      next_count = count + CNT_W'(1);
    end
  end

  // Register the count
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      count <= '0;
    end else if (clk_en) begin
      count <= next_count;
    end
  end

endmodule // acc_prescaler

// ==== hw/acc_control.sv ====
/*
  Converter channel, reference and conversion control with its registers.
  Assumes a same-clock register port, trigger lines and status word bit
  from same-clock logic, and a converter core that offers a result.
*/
// Notes on behaviour
// - Two-bit field picks the reference source
// - Reference change waits for conversion end
// - Alignment bit reshapes result reads at once
// - Codes pick single inputs, bandgap, ground
// - Codes pick differential pairs and gains
// - Channel change waits for conversion end
// - Enable powers; clearing aborts the conversion
// - Single mode start per conversion; free once
// - First conversion 25 ticks, later 13
// - Start reads busy; writing zero ignored
// - Auto trigger starts on selected rising edge
// - Done flag sets at each conversion end, even when the result load is skipped
// - Flag clears on vector entry or one
// - Interrupt needs flag, local and global enable
// - Prescaler divides by 2 up to 128
// - Low byte read freezes result until high
// - Switching to free running makes no trigger
// - Cleared-to-set source switch counts as edge
`timescale 1ns/1ps
module acc_control
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:1] trigger_in,
  input wire logic global_irq_enable,
  input wire logic irq_vector_ack,
  input wire logic [9:0] conv_result,
  output acc_analog_s analog_ctrl,
  output logic conversion_done_irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic converter_enable, next_converter_enable;     // Power bit
  logic auto_trigger_enable, next_auto_trigger_enable;
  logic conversion_done_flag, next_conversion_done_flag;
  logic conversion_done_irq_enable, next_conversion_done_irq_enable;
  logic [2:0] clock_prescale_select, next_clock_prescale_select;
  logic [1:0] reference_select, next_reference_select;
  logic left_align_result, next_left_align_result;
  logic [4:0] channel_gain_select, next_channel_gain_select;
  logic [2:0] trigger_source_select, next_trigger_source_select;
  logic [1:0] applied_ref, next_applied_ref;         // Held during conversion
  logic [4:0] applied_channel, next_applied_channel; // Held during conversion
  acc_state_e state, next_state;
  logic [4:0] tick_count, next_tick_count;           // Ticks in this conversion
  logic first_pending, next_first_pending;           // Next run initialises
  logic [9:0] result, next_result;
  logic result_locked, next_result_locked;
  logic trig_prev, next_trig_prev;                   // Last selected level
  logic [7:0] next_reg_rdata;
  acc_analog_s next_analog_ctrl;

  // ----------------------------------------------------------------
  // Decoded strobes and events
  // ----------------------------------------------------------------
  logic tick;          // Converter clock tick
  logic busy;          // Conversion running
  logic wr_csr;        // Write to control and status
  logic wr_chr;        // Write to channel register
  logic wr_trg;        // Write to trigger select
  logic rd_low;        // Read of result low byte
  logic rd_high;       // Read of result high byte
  logic trig_level;    // Selected trigger line
  logic trig_edge;     // Rising edge on it
  logic conv_last;     // Final tick of conversion
  logic sw_start;      // Software start
  logic auto_start;    // Trigger start
  logic free_restart;  // Back to back restart
  logic start_now;     // Conversion begins
  logic flag_clear;    // Clear request for flag
  logic [4:0] conv_len; // Ticks of current conversion

  // ----------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------
  // Maps the channel code onto inputs and gain for the analog side
  function automatic acc_analog_s decode_channel(input acc_analog_s base,
                                                 input logic [4:0] ch);
    acc_analog_s d;
    d = base;
    d.single_ended = 1'b0;
    d.bandgap = 1'b0;
    d.ground = 1'b0;
    d.pos_input = ch[2:0];
    d.neg_input = 2'd0;
    d.gain = GAIN_NONE;
    if (ch[4:3] == 2'b00) begin
      d.single_ended = 1'b1;
    end else if (ch == CH_BANDGAP) begin
      d.bandgap = 1'b1;
    end else if (ch == CH_GROUND) begin
      d.ground = 1'b1;
    end else if (ch[4:3] == 2'b01) begin
      // Gain pairs: negative input 0 or 2, gain from bit 1
      d.pos_input = {1'b0, ch[2], ch[0]};
      d.neg_input = ch[2] ? 2'd2 : 2'd0;
      d.gain = ch[1] ? GAIN_200X : GAIN_10X;
    end else begin
      // Unity pairs: negative input 1 then 2
      d.neg_input = ch[3] ? 2'd2 : 2'd1;
      d.gain = GAIN_1X;
    end
    return d;
  endfunction

  // ----------------------------------------------------------------
  // Converter clock
  // ----------------------------------------------------------------
  acc_prescaler #(
    .CNT_W(8)
  ) u_prescaler (
    .core_clk(core_clk),
    .reset(reset),
    .clk_en(clk_en),
    .run(converter_enable),
    .sel(clock_prescale_select),
    .tick(tick)
  );

  // Interrupt request; combinational so it drops with the flag
  assign conversion_done_irq = conversion_done_flag && conversion_done_irq_enable
                               && global_irq_enable;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    busy = (state == ST_CONVERT);
    wr_csr = reg_write && (reg_addr == ADDR_CONTROL_STATUS);
    wr_chr = reg_write && (reg_addr == ADDR_CHANNEL_REF);
    wr_trg = reg_write && (reg_addr == ADDR_TRIGGER_SELECT);
    rd_low = reg_read && (reg_addr == ADDR_RESULT_LOW);
    rd_high = reg_read && (reg_addr == ADDR_RESULT_HIGH);

    // Plain register fields
    next_converter_enable = wr_csr ? reg_wdata[CSR_ENABLE_BIT] : converter_enable;
    next_auto_trigger_enable = wr_csr ? reg_wdata[CSR_AUTO_BIT] : auto_trigger_enable;
    next_conversion_done_irq_enable = wr_csr ? reg_wdata[CSR_IRQ_EN_BIT]
                                             : conversion_done_irq_enable;
    next_clock_prescale_select = wr_csr ? reg_wdata[CSR_PRESCALE_LSB +: 3]
                                        : clock_prescale_select;
    next_reference_select = wr_chr ? reg_wdata[CHR_REF_LSB +: 2] : reference_select;
    next_left_align_result = wr_chr ? reg_wdata[CHR_ALIGN_BIT] : left_align_result;
    next_channel_gain_select = wr_chr ? reg_wdata[CHR_CHANNEL_LSB +: 5]
                                      : channel_gain_select;
    next_trigger_source_select = wr_trg ? reg_wdata[2:0] : trigger_source_select;

    // Trigger edge; free running code reads as low, so switching to it
    // never fires, while a switch onto a high line does
    trig_level = (trigger_source_select == TRIG_FREE_RUN) ? 1'b0
                 : trigger_in[trigger_source_select];
    trig_edge = trig_level && !trig_prev;
    next_trig_prev = trig_level;

    // Conversion timing
    conv_len = first_pending ? FIRST_CONV_TICKS : NORMAL_CONV_TICKS;
    conv_last = busy && tick && next_converter_enable && tick_count == conv_len - 5'd1;

    // Start sources; all need the converter to stay on
    sw_start = wr_csr && reg_wdata[CSR_START_BIT] && next_converter_enable;
    auto_start = auto_trigger_enable && converter_enable && next_converter_enable
                 && trig_edge;
    free_restart = conv_last && auto_trigger_enable && next_converter_enable
                   && (trigger_source_select == TRIG_FREE_RUN);
    start_now = (!busy && (sw_start || auto_start)) || free_restart;

    // Sequencer; disabling wins over everything
    next_state = state;
    next_tick_count = tick_count;
    if (!next_converter_enable) begin
      next_state = ST_IDLE;
      next_tick_count = 5'd0;
    end else if (start_now) begin
      next_state = ST_CONVERT;
      next_tick_count = 5'd0;
    end else if (conv_last) begin
      next_state = ST_IDLE;
      next_tick_count = 5'd0;
    end else if (busy && tick) begin
      next_tick_count = tick_count + 5'd1;
    end

    // Initialisation pending after each power up, spent at completion
    next_first_pending = first_pending;
    if (next_converter_enable && !converter_enable) begin
      next_first_pending = 1'b1;
    end else if (conv_last) begin
      next_first_pending = 1'b0;
    end

    // Selections apply only between conversions
    next_applied_ref = applied_ref;
    next_applied_channel = applied_channel;
    if (!busy || conv_last) begin
      next_applied_ref = next_reference_select;
      next_applied_channel = next_channel_gain_select;
    end

    // Done flag; a completion in the clearing cycle keeps it set
    flag_clear = (wr_csr && reg_wdata[CSR_FLAG_BIT]) || irq_vector_ack;
    next_conversion_done_flag = (conversion_done_flag && !flag_clear)
                                || conv_last;

    // Result load, skipped while a low byte read is outstanding
    next_result = result;
    if (conv_last && !result_locked) begin
      next_result = conv_result;
    end
    next_result_locked = result_locked;
    if (rd_high) begin
      next_result_locked = 1'b0;
    end else if (rd_low) begin
      next_result_locked = 1'b1;
    end

    // Read data, valid only in the cycle after the strobe
    next_reg_rdata = 8'h00;
    if (reg_read) begin
      case (reg_addr)
        ADDR_CONTROL_STATUS: begin
          next_reg_rdata = {converter_enable, busy, auto_trigger_enable,
                            conversion_done_flag, conversion_done_irq_enable,
                            clock_prescale_select};
        end
        ADDR_CHANNEL_REF: begin
          next_reg_rdata = {reference_select, left_align_result, channel_gain_select};
        end
        ADDR_TRIGGER_SELECT: begin
          next_reg_rdata = {5'h00, trigger_source_select};
        end
        ADDR_RESULT_LOW: begin
          // Alignment is applied at read time, so it acts at once
          next_reg_rdata = left_align_result ? {result[1:0], 6'h00}
                                             : result[7:0];
        end
        ADDR_RESULT_HIGH: begin
          next_reg_rdata = left_align_result ? result[9:2]
                                             : {6'h00, result[9:8]};
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end

    // Analog control bundle
    next_analog_ctrl.powered = next_converter_enable;
    next_analog_ctrl.converting = (next_state == ST_CONVERT);
    next_analog_ctrl.conv_start = start_now;
    next_analog_ctrl.conv_clk_tick = tick;
    next_analog_ctrl.ref_select = acc_ref_e'(next_applied_ref);
    next_analog_ctrl.single_ended = 1'b0;
    next_analog_ctrl.bandgap = 1'b0;
    next_analog_ctrl.ground = 1'b0;
    next_analog_ctrl.pos_input = 3'h0;
    next_analog_ctrl.neg_input = 2'h0;
    next_analog_ctrl.gain = GAIN_NONE;
    next_analog_ctrl = decode_channel(next_analog_ctrl, next_applied_channel);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      converter_enable <= CONTROL_STATUS_RESET[CSR_ENABLE_BIT];
      auto_trigger_enable <= CONTROL_STATUS_RESET[CSR_AUTO_BIT];
      conversion_done_flag <= CONTROL_STATUS_RESET[CSR_FLAG_BIT];
      conversion_done_irq_enable <= CONTROL_STATUS_RESET[CSR_IRQ_EN_BIT];
      clock_prescale_select <= CONTROL_STATUS_RESET[CSR_PRESCALE_LSB +: 3];
      reference_select <= CHANNEL_REF_RESET[CHR_REF_LSB +: 2];
      left_align_result <= CHANNEL_REF_RESET[CHR_ALIGN_BIT];
      channel_gain_select <= CHANNEL_REF_RESET[CHR_CHANNEL_LSB +: 5];
      trigger_source_select <= TRIGGER_SELECT_RESET;
      applied_ref <= CHANNEL_REF_RESET[CHR_REF_LSB +: 2];
      applied_channel <= CHANNEL_REF_RESET[CHR_CHANNEL_LSB +: 5];
      state <= ST_IDLE;
      tick_count <= 5'd0;
      first_pending <= 1'b0;
      result <= RESULT_RESET;
      result_locked <= 1'b0;
      trig_prev <= 1'b0;
      reg_rdata <= 8'h00;
      analog_ctrl <= '0;
    end else if (clk_en) begin
      converter_enable <= next_converter_enable;
      auto_trigger_enable <= next_auto_trigger_enable;
      conversion_done_flag <= next_conversion_done_flag;
      conversion_done_irq_enable <= next_conversion_done_irq_enable;
      clock_prescale_select <= next_clock_prescale_select;
      reference_select <= next_reference_select;
      left_align_result <= next_left_align_result;
      channel_gain_select <= next_channel_gain_select;
      trigger_source_select <= next_trigger_source_select;
      applied_ref <= next_applied_ref;
      applied_channel <= next_applied_channel;
      state <= next_state;
      tick_count <= next_tick_count;
      first_pending <= next_first_pending;
      result <= next_result;
      result_locked <= next_result_locked;
      trig_prev <= next_trig_prev;
      reg_rdata <= next_reg_rdata;
      analog_ctrl <= next_analog_ctrl;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Independent tick count for the length check
  logic [5:0] chk_ticks;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chk_ticks <= 6'd0;
    end else if (clk_en) begin
      if (start_now || !busy) begin
        chk_ticks <= 6'd0;
      end else if (tick) begin
        chk_ticks <= chk_ticks + 6'd1;
      end
    end
  end

  default clocking cb @(posedge core_clk iff clk_en); endclocking
  default disable iff (reset);

  sequence s_conv_end;
    busy && conv_last;
  endsequence
  sequence s_stays_on;
    converter_enable [*2];
  endsequence

  a_start_goes_busy: assert property ((!busy && sw_start) |=> busy)
    else $error("software start did not begin a conversion");
  a_disable_aborts: assert property ((busy && wr_csr && !reg_wdata[CSR_ENABLE_BIT])
    |=> !busy && !analog_ctrl.powered && !analog_ctrl.converting)
    else $error("disable did not abort the conversion");
  a_done_sets_flag: assert property (s_conv_end |=> conversion_done_flag)
    else $error("completion did not set the flag");
  a_irq_gating: assert property ((s_conv_end ##1 (conversion_done_irq_enable
    && global_irq_enable)) |-> conversion_done_irq)
    else $error("completion with both enables gave no interrupt");
  a_select_held: assert property ((busy && $past(busy) && !$past(conv_last))
    |-> $stable(applied_ref) && $stable(applied_channel))
    else $error("selection changed mid conversion");
  a_conv_length: assert property (s_conv_end
    |-> (chk_ticks + 6'd1) == (first_pending ? 6'd25 : 6'd13))
    else $error("conversion length wrong");
  a_result_locked: assert property ((result_locked && !rd_high) |=> $stable(result))
    else $error("result changed while low byte read pending");
  a_free_run_next: assert property ((s_conv_end ##0 (auto_trigger_enable
    && trigger_source_select == TRIG_FREE_RUN)) ##1 s_stays_on |-> busy)
    else $error("free running did not restart");
  a_flag_clear: assert property ((conversion_done_flag && irq_vector_ack && !conv_last)
    |=> !conversion_done_flag)
    else $error("vector entry did not clear the flag");

endmodule // acc_control

// ==== sim/acc_core_model.sv ====
/*
  Converter core stand-in: offers a fresh result for each conversion.
  Assumes the control bundle arrives registered on the same clock.
*/
`timescale 1ns/1ps
module acc_core_model
  import acc_pkg::*;
(
  input wire logic core_clk,
  input wire acc_analog_s analog_ctrl,
  output logic [9:0] conv_result,
  output logic [9:0] model_val
);
  // New sample at each start, so a stale load shows up
  initial model_val = 10'h2B5;
  always @(posedge core_clk) begin
    if (analog_ctrl.conv_start) begin
      model_val <= model_val * 10'h0A7 + 10'h13D;
    end
  end
  // Outside a conversion the lines show junk, never the last value
  assign conv_result = analog_ctrl.converting ? model_val : ~model_val;
endmodule  // acc_core_model

// ==== sim/tb.sv ====
/*
  Bench for the converter control block with a core stand-in.
  Assumes one 100 MHz clock and the register port of the block.
*/
`timescale 1ns/1ps
module tb
  import acc_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic reg_write = 1'b0, reg_read = 1'b0, rd_seen = 1'b0, irq_vector_ack = 1'b0;
  logic global_irq_enable = 1'b0;
  logic conversion_done_irq;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [7:1] trigger_in = 7'h00;
  logic [9:0] conv_result, model_val, v;
  logic [4:0] ch;
  logic [2:0] ps;
  acc_analog_s analog_ctrl;
  logic [15:0] exp_q[$];
  int failures = 0, checked = 0, d1, d2, d3;
  always #5 core_clk = ~core_clk;
  acc_control u_acc_control (.core_clk, .reset, .clk_en(1'b1), .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .trigger_in, .global_irq_enable, .irq_vector_ack,
    .conv_result, .analog_ctrl, .conversion_done_irq);
  acc_core_model u_acc_core_model (.core_clk, .analog_ctrl, .conv_result, .model_val);
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Strobe cycle then a quiet cycle, so no strobe is set twice at one edge
  task automatic op(logic w, logic r, logic [7:0] a, logic [7:0] d);
    reg_write <= w;
    reg_read <= r;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    op(1'b1, 1'b0, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_q.push_back({8'h00, e});
    op(1'b0, 1'b1, a, 8'h00);
  endtask
  // Cycles until the conversion ends, bounded
  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
      if (n > 3000) begin
        failures++;
        tally_and_finish();
      end
    end while (analog_ctrl.converting !== 1'b0);
    @(posedge core_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge core_clk) rd_seen <= reg_read;
  always @(negedge core_clk) begin
    if (rd_seen) begin
      chk({8'h00, reg_rdata}, exp_q.pop_front());
    end
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h01DA8368));
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    rd(ADDR_CONTROL_STATUS, 8'h00);
    rd(ADDR_CHANNEL_REF, 8'h00);
    wr(8'h7F, 8'hFF);
    rd(8'h7F, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ch = 5'($urandom_range(7));
      wr(ADDR_CHANNEL_REF, {i[1:0], 1'b0, ch});
      rd(ADDR_CHANNEL_REF, {i[1:0], 1'b0, ch});
      chk({10'h000, analog_ctrl.ref_select, analog_ctrl.single_ended, analog_ctrl.pos_input},
        {10'h000, i[1:0], 1'b1, ch[2:0]});
    end
    wr(ADDR_CHANNEL_REF, 8'h1E);
    chk(16'({analog_ctrl.bandgap, analog_ctrl.ground}), 16'h0002);
    wr(ADDR_CHANNEL_REF, 8'h1F);
    chk(16'({analog_ctrl.bandgap, analog_ctrl.ground}), 16'h0001);
    wr(ADDR_CHANNEL_REF, 8'h0E);
    chk({9'h000, analog_ctrl.pos_input, analog_ctrl.neg_input, analog_ctrl.gain},
      {9'h000, 3'h2, 2'h2, GAIN_200X});
    wr(ADDR_CHANNEL_REF, 8'h09);
    chk({9'h000, analog_ctrl.pos_input, analog_ctrl.neg_input, analog_ctrl.gain},
      {9'h000, 3'h1, 2'h0, GAIN_10X});
    wr(ADDR_CHANNEL_REF, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'h40);
    rd(ADDR_CONTROL_STATUS, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'hC0);
    wait_done(d1);
    v = model_val;
    rd(ADDR_CONTROL_STATUS, 8'h90);
    rd(ADDR_RESULT_LOW, v[7:0]);
    rd(ADDR_RESULT_HIGH, {6'h00, v[9:8]});
    wr(ADDR_CHANNEL_REF, 8'h20);
    rd(ADDR_RESULT_HIGH, v[9:2]);
    global_irq_enable <= 1'b1;
    wr(ADDR_CONTROL_STATUS, 8'h88);
    chk(16'(conversion_done_irq), 16'h0001);
    global_irq_enable <= 1'b0;
    @(posedge core_clk);
    chk(16'(conversion_done_irq), 16'h0000);
    irq_vector_ack <= 1'b1;
    @(posedge core_clk);
    irq_vector_ack <= 1'b0;
    rd(ADDR_CONTROL_STATUS, 8'h88);
    wr(ADDR_CONTROL_STATUS, 8'hC8);
    rd(ADDR_CONTROL_STATUS, 8'hC8);
    wr(ADDR_CHANNEL_REF, 8'hF3);
    chk(16'(analog_ctrl.pos_input), 16'h0000);
    wait_done(d2);
    chk(16'((d1 - d2 - 4) >= 23 && (d1 - d2 - 4) <= 25), 16'h0001);
    chk({9'h000, analog_ctrl.ref_select, analog_ctrl.pos_input, analog_ctrl.neg_input},
      {9'h000, 2'h3, 3'h3, 2'h1});
    chk(16'(analog_ctrl.gain), 16'(GAIN_1X));
    wr(ADDR_CONTROL_STATUS, 8'h98);
    rd(ADDR_CONTROL_STATUS, 8'h88);
    wr(ADDR_CONTROL_STATUS, 8'hC8);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    chk({14'h0000, analog_ctrl.powered, analog_ctrl.converting}, 16'h0000);
    rd(ADDR_CONTROL_STATUS, 8'h00);
    wr(ADDR_TRIGGER_SELECT, 8'hF9);
    rd(ADDR_TRIGGER_SELECT, 8'h01);
    wr(ADDR_CONTROL_STATUS, 8'hA0);
    trigger_in <= 7'h01;
    repeat (4) @(posedge core_clk);
    wait_done(d3);
    chk(16'(d3 > 40), 16'h0001);
    rd(ADDR_CONTROL_STATUS, 8'hB0);
    // Slower converter clocks stretch a normal conversion by the factor
    ps = 3'($urandom_range(7, 1));
    wr(ADDR_CONTROL_STATUS, {5'b11000, ps});
    wait_done(d3);
    chk(16'(d3 > 12 * (1 << ps) && d3 <= 13 * (1 << ps)), 16'h0001);
    // Switching to free running with the flag set must not start
    wr(ADDR_CONTROL_STATUS, 8'hA0);
    wr(ADDR_TRIGGER_SELECT, 8'h00);
    rd(ADDR_CONTROL_STATUS, 8'hB0);
    trigger_in <= 7'h02;
    wr(ADDR_TRIGGER_SELECT, 8'h02);
    rd(ADDR_CONTROL_STATUS, 8'hF0);
    wait_done(d3);
    v = model_val;
    // Low byte read locks the result across free running completions
    rd(ADDR_RESULT_LOW, {v[1:0], 6'h00});
    wr(ADDR_TRIGGER_SELECT, 8'h00);
    wr(ADDR_CONTROL_STATUS, 8'hF0);
    repeat (60) @(posedge core_clk);
    rd(ADDR_CONTROL_STATUS, 8'hF0);
    rd(ADDR_RESULT_HIGH, v[9:2]);
    wr(ADDR_CONTROL_STATUS, 8'h00);
    tally_and_finish();
  end
endmodule  // tb
